/* File: logic/flash_host_ctrl.sv */
// flash_host_ctrl: host-side controller issuing flash command sequences,
// polling status and driving reset/protect pins, run from Avalon-MM.
// assumes an external pull-up on the status pin and a synchronous flash.
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter logic [7:0] CMD_CLEAR_STATUS = 8'h50,
  parameter logic [7:0] CMD_LOCK_SETUP = 8'h60,
  parameter logic [7:0] CMD_LOCK_SET_CONFIRM = 8'h01,
  parameter logic [7:0] CMD_LOCK_CLEAR_CONFIRM = 8'hD0,
  parameter logic [7:0] CMD_STS_CONFIG = 8'hB8
)
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic [FLASH_AW-1:0] flash_addr_o,
  output logic [FLASH_DW-1:0] flash_data_o,
  output logic flash_data_oe_o,
  input wire logic [FLASH_DW-1:0] flash_data_i,
  output logic flash_ce_n_o,
  output logic flash_we_n_o,
  output logic flash_oe_n_o,
  output logic reset_powerdown_pin_n_o,
  output logic protect_release_o,
  input wire logic status_output_pin_i
);

  typedef enum logic [2:0] {
    S_IDLE, S_WR1, S_WR2, S_WAIT_PIN, S_POLL, S_READ, S_ARRAY
  } seq_state_t;

  // first command word of each operation
  function automatic logic [7:0] first_word(input op_t op);
    unique case (op)
      OP_READ_STATUS: first_word = CMD_READ_STATUS;
      OP_CLEAR_STATUS: first_word = CMD_CLEAR_STATUS;
      OP_CLEAR_LOCKS: first_word = CMD_LOCK_SETUP;
      OP_STS_CONFIG: first_word = CMD_STS_CONFIG;
      OP_BLOCK_ERASE: first_word = CMD_ERASE_SETUP;
      OP_CHIP_ERASE: first_word = CMD_CHIP_ERASE_SETUP;
      OP_WORD_WRITE: first_word = CMD_WRITE_SETUP;
      OP_SET_LOCK: first_word = CMD_LOCK_SETUP;
      default: first_word = CMD_READ_ARRAY;
    endcase
  endfunction

  // operations that run the write engine and end with a completion
  function automatic logic engine_op(input op_t op);
    engine_op = (op == OP_CLEAR_LOCKS) || (op == OP_BLOCK_ERASE) ||
                (op == OP_CHIP_ERASE) || (op == OP_WORD_WRITE) ||
                (op == OP_SET_LOCK);
  endfunction

  // does the pin mode pulse at the end of this operation
  function automatic logic pulse_for(input logic [1:0] mode, input op_t op);
    logic erase_class;
    erase_class = (op == OP_BLOCK_ERASE) || (op == OP_CHIP_ERASE) ||
                  (op == OP_CLEAR_LOCKS);
    unique case (mode)
      STS_PULSE_ERASE: pulse_for = erase_class;
      STS_PULSE_WRITE: pulse_for = engine_op(op) && !erase_class;
      STS_PULSE_ALL: pulse_for = engine_op(op);
      default: pulse_for = 1'b0;
    endcase
  endfunction

  seq_state_t state_ff, nxt_state;
  op_t op_ff, nxt_op;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [FLASH_AW-1:0] addr_reg_ff, nxt_addr_reg;
  logic [FLASH_AW-1:0] op_addr_ff, nxt_op_addr;
  logic [7:0] wdata_reg_ff, nxt_wdata_reg;
  logic [7:0] op_wdata_ff, nxt_op_wdata;
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic [3:0] ctrl_ff, nxt_ctrl;
  logic [1:0] sts_mode_ff, nxt_sts_mode;
  logic [7:0] result_sr_ff, nxt_result_sr;
  logic locks_unknown_ff, nxt_locks_unknown;
  logic pend_ff, nxt_pend;
  logic [9:0] rec_cnt_ff, nxt_rec_cnt;
  logic rd_ack_ff, nxt_rd_ack;
  logic [31:0] readdata_ff, nxt_readdata;

  logic bus_start, bus_ready, bus_done;
  logic [7:0] bus_rdata;
  bus_req_t bus_req;
  pin_drive_t pins;
  logic busy, cmd_wr, cmd_stall, rp_high;

  assign rp_high = ctrl_ff[CTRL_RP_BIT];
  assign busy = (state_ff != S_IDLE) || pend_ff;
  assign cmd_stall = busy || (rec_cnt_ff != 10'h000) || !rp_high;
  assign cmd_wr = write_i && (address_i == REG_CMD) && !cmd_stall;

  // bus request for the current sequencing state
  always_comb begin
    bus_req = '{write: 1'b1, addr: op_addr_ff, data: first_word(op_ff)};
    bus_start = 1'b0;
    unique case (state_ff)
      S_IDLE, S_WAIT_PIN: bus_start = 1'b0;
      S_WR1: bus_start = 1'b1;
      S_WR2: begin
        bus_start = 1'b1;
        unique case (op_ff)
          OP_STS_CONFIG: bus_req.data = cfg_ff;
          OP_WORD_WRITE: bus_req.data = op_wdata_ff;
          OP_SET_LOCK: bus_req.data = CMD_LOCK_SET_CONFIRM;
          OP_CLEAR_LOCKS: bus_req.data = CMD_LOCK_CLEAR_CONFIRM;
          default: bus_req.data = CMD_CONFIRM;
        endcase
      end
      S_POLL, S_READ: begin
        bus_start = 1'b1;
        bus_req.write = 1'b0;
      end
      S_ARRAY: begin
        bus_start = 1'b1;
        bus_req.data = CMD_READ_ARRAY;
      end
    endcase
    bus_start = bus_start && !pend_ff && bus_ready && rp_high;
  end

  // command sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_cfg = cfg_ff;
    nxt_op_addr = op_addr_ff;
    nxt_op_wdata = op_wdata_ff;
    nxt_rd_data = rd_data_ff;
    nxt_sts_mode = sts_mode_ff;
    nxt_result_sr = result_sr_ff;
    nxt_locks_unknown = locks_unknown_ff;
    nxt_pend = (pend_ff || bus_start) && !bus_done;
    unique case (state_ff)
      S_IDLE: begin
        if (cmd_wr) begin
          nxt_op = op_t'(writedata_i[3:0]);
          nxt_cfg = writedata_i[CMDREG_CFG_LSB +: 8];
          nxt_op_addr = addr_reg_ff;
          nxt_op_wdata = wdata_reg_ff;
          nxt_state = S_WR1;
        end
      end
      S_WR1: begin
        if (bus_done) begin
          unique case (op_ff)
            OP_READ_STATUS, OP_READ_ARRAY: nxt_state = S_READ;
            OP_CLEAR_STATUS: begin
              nxt_result_sr = 8'h80;
              nxt_state = S_IDLE;
            end
            default: nxt_state = S_WR2;
          endcase
        end
      end
      S_WR2: begin
        if (bus_done) begin
          if (op_ff == OP_STS_CONFIG) begin
            nxt_sts_mode = cfg_ff[1:0];
            nxt_state = S_IDLE;
          end else if (ctrl_ff[CTRL_USE_PIN_BIT]) begin
            nxt_state = S_WAIT_PIN;
          end else begin
            nxt_state = S_POLL;
          end
        end
      end
      S_WAIT_PIN: begin
        // level mode: released pin; pulse mode: the low pulse if this op pulses, else no wait
        if (sts_mode_ff == STS_LEVEL) begin
          if (status_output_pin_i) nxt_state = S_POLL;
        end else if (pulse_for(sts_mode_ff, op_ff)) begin
          if (!status_output_pin_i) nxt_state = S_POLL;
        end else begin
          nxt_state = S_POLL;
        end
      end
      S_POLL: begin
        // status comes back on every read after the command
        if (bus_done && bus_rdata[SR_READY_BIT]) begin
          nxt_result_sr = bus_rdata & SR_VALID_MASK;
          if (op_ff == OP_CLEAR_LOCKS) nxt_locks_unknown = 1'b0;
          nxt_state = ctrl_ff[CTRL_AUTO_ARRAY_BIT] ? S_ARRAY : S_IDLE;
        end
      end
      S_READ: begin
        if (bus_done) begin
          if (op_ff == OP_READ_STATUS) begin
            nxt_result_sr = bus_rdata & SR_VALID_MASK;
          end else begin
            nxt_rd_data = bus_rdata;
          end
          nxt_state = S_IDLE;
        end
      end
      S_ARRAY: begin
        if (bus_done) nxt_state = S_IDLE;
      end
    endcase
    // reset pin pulled low: abort, defaults return, locks may be lost
    if (!rp_high) begin
      nxt_state = S_IDLE;
      nxt_sts_mode = STS_LEVEL;
      if (op_ff == OP_CLEAR_LOCKS && (state_ff == S_WAIT_PIN ||
          state_ff == S_POLL)) begin
        nxt_locks_unknown = 1'b1;
      end
    end
  end

  // software registers and recovery after reset pin release
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_addr_reg = addr_reg_ff;
    nxt_wdata_reg = wdata_reg_ff;
    nxt_rec_cnt = rec_cnt_ff;
    if (write_i && !waitrequest_o) begin
      unique case (address_i)
        REG_CTRL: nxt_ctrl = writedata_i[3:0];
        REG_ADDR: nxt_addr_reg = writedata_i[FLASH_AW-1:0];
        REG_DATA: nxt_wdata_reg = writedata_i[7:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (!rp_high) begin
      nxt_rec_cnt = RP_RECOVER_CYC;
    end else if (rec_cnt_ff != 10'h000) begin
      nxt_rec_cnt = rec_cnt_ff - 10'h001;
    end
  end

  // register read path: answer one cycle after the request
  always_comb begin
    nxt_rd_ack = read_i && !rd_ack_ff;
    nxt_readdata = readdata_ff;
    if (read_i && !rd_ack_ff) begin
      unique case (address_i)
        REG_CTRL: nxt_readdata = {28'h0000000, ctrl_ff};
        REG_CMD: nxt_readdata = {20'h00000, cfg_ff, op_ff};
        REG_ADDR: nxt_readdata = {11'h000, addr_reg_ff};
        REG_DATA: nxt_readdata = {24'h000000, rd_data_ff};
        REG_STATUS: begin
          nxt_readdata = 32'h00000000;
          nxt_readdata[STAT_BUSY_BIT] = busy;
          nxt_readdata[STAT_SEQ_ERR_BIT] =
            result_sr_ff[SR_ERASE_ERR_BIT] &&
            result_sr_ff[SR_WRITE_ERR_BIT];
          nxt_readdata[STAT_LOCKS_UNKNOWN_BIT] = locks_unknown_ff;
          nxt_readdata[STAT_STS_MODE_LSB +: 2] = sts_mode_ff;
          nxt_readdata[STAT_SR_LSB +: 8] = result_sr_ff;
        end
        default: nxt_readdata = 32'h00000000;
      endcase
    end
  end

  // registers only
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_ff <= S_IDLE;
      op_ff <= OP_READ_STATUS;
      cfg_ff <= 8'h00;
      addr_reg_ff <= '0;
      op_addr_ff <= '0;
      wdata_reg_ff <= 8'h00;
      op_wdata_ff <= 8'h00;
      rd_data_ff <= 8'h00;
      ctrl_ff <= CTRL_RESET;
      sts_mode_ff <= STS_LEVEL;
      result_sr_ff <= 8'h00;
      locks_unknown_ff <= 1'b0;
      pend_ff <= 1'b0;
      rec_cnt_ff <= RP_RECOVER_CYC;
      rd_ack_ff <= 1'b0;
      readdata_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      cfg_ff <= nxt_cfg;
      addr_reg_ff <= nxt_addr_reg;
      op_addr_ff <= nxt_op_addr;
      wdata_reg_ff <= nxt_wdata_reg;
      op_wdata_ff <= nxt_op_wdata;
      rd_data_ff <= nxt_rd_data;
      ctrl_ff <= nxt_ctrl;
      sts_mode_ff <= nxt_sts_mode;
      result_sr_ff <= nxt_result_sr;
      locks_unknown_ff <= nxt_locks_unknown;
      pend_ff <= nxt_pend;
      rec_cnt_ff <= nxt_rec_cnt;
      rd_ack_ff <= nxt_rd_ack;
      readdata_ff <= nxt_readdata;
    end
  end

  flash_bus_cycle u_cycle (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .start_i(bus_start),
    .req_i(bus_req),
    .data_i(flash_data_i),
    .ready_o(bus_ready),
    .done_o(bus_done),
    .rdata_o(bus_rdata),
    .pins_o(pins)
  );

  // bus handshake and pin outputs
  assign waitrequest_o = (read_i && !rd_ack_ff) ||
                         (write_i && (address_i == REG_CMD) && cmd_stall);
  assign readdata_o = readdata_ff;
  assign flash_addr_o = pins.addr;
  assign flash_data_o = pins.data;
  assign flash_data_oe_o = pins.data_oe;
  assign flash_ce_n_o = pins.ce_n;
  assign flash_we_n_o = pins.we_n;
  assign flash_oe_n_o = pins.oe_n;
  assign reset_powerdown_pin_n_o = ctrl_ff[CTRL_RP_BIT];
  assign protect_release_o = ctrl_ff[CTRL_PROTECT_BIT];

endmodule

/* File: common/flash_host_pkg.sv */
// flash_host_pkg: constants and types for the flash command controller.
// assumes a 250 MHz clock and an x8 flash data bus.
package flash_host_pkg;

  // clock and timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WE_PULSE_NS = 50;
  localparam int READ_ACCESS_NS = 100;
  localparam int RP_RECOVER_NS = 1000;
  localparam logic [9:0] WE_PULSE_CYC =
    10'((WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [9:0] READ_ACCESS_CYC =
    10'((READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [9:0] RP_RECOVER_CYC =
    10'((RP_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // flash bus widths
  localparam int FLASH_AW = 21;
  localparam int FLASH_DW = 8;

  // command words known for this part
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE_SETUP = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;

  // operation_state_flags bit positions
  localparam int SR_READY_BIT = 7;
  localparam int SR_ERASE_SUSP_BIT = 6;
  localparam int SR_ERASE_ERR_BIT = 5;
  localparam int SR_WRITE_ERR_BIT = 4;
  localparam int SR_SUPPLY_LOW_BIT = 3;
  localparam int SR_WRITE_SUSP_BIT = 2;
  localparam int SR_PROTECT_BIT = 1;
  localparam logic [7:0] SR_VALID_MASK = 8'hFE;
  localparam int XSR_BUF_BIT = 7;

  // status pin configuration codes
  localparam logic [1:0] STS_LEVEL = 2'h0;
  localparam logic [1:0] STS_PULSE_ERASE = 2'h1;
  localparam logic [1:0] STS_PULSE_WRITE = 2'h2;
  localparam logic [1:0] STS_PULSE_ALL = 2'h3;

  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CMD = 5'h04;
  localparam logic [4:0] REG_ADDR = 5'h08;
  localparam logic [4:0] REG_DATA = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;

  // control register fields
  localparam int CTRL_RP_BIT = 0;
  localparam int CTRL_PROTECT_BIT = 1;
  localparam int CTRL_USE_PIN_BIT = 2;
  localparam int CTRL_AUTO_ARRAY_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // command register fields
  localparam int CMDREG_CFG_LSB = 8;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SEQ_ERR_BIT = 1;
  localparam int STAT_LOCKS_UNKNOWN_BIT = 2;
  localparam int STAT_STS_MODE_LSB = 4;
  localparam int STAT_SR_LSB = 8;

  typedef enum logic [3:0] {
    OP_READ_STATUS = 4'h0,
    OP_CLEAR_STATUS = 4'h1,
    OP_CLEAR_LOCKS = 4'h2,
    OP_STS_CONFIG = 4'h3,
    OP_READ_ARRAY = 4'h4,
    OP_BLOCK_ERASE = 4'h5,
    OP_CHIP_ERASE = 4'h6,
    OP_WORD_WRITE = 4'h7,
    OP_SET_LOCK = 4'h8
  } op_t;

  typedef struct packed {
    logic write;
    logic [FLASH_AW-1:0] addr;
    logic [FLASH_DW-1:0] data;
  } bus_req_t;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic data_oe;
    logic [FLASH_DW-1:0] data;
    logic [FLASH_AW-1:0] addr;
  } pin_drive_t;

endpackage

/* File: logic/flash_bus_cycle.sv */
// flash_bus_cycle: one asynchronous write or read cycle on the flash pins.
// assumes the flash data pins are synchronous to clock_i when sampled.
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire bus_req_t req_i,
  input wire logic [FLASH_DW-1:0] data_i,
  output logic ready_o,
  output logic done_o,
  output logic [FLASH_DW-1:0] rdata_o,
  output pin_drive_t pins_o
);

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD} cyc_state_t;

  cyc_state_t state_ff, nxt_state;
  bus_req_t req_ff, nxt_req;
  logic [9:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;
  logic [FLASH_DW-1:0] rdata_ff, nxt_rdata;
  pin_drive_t pins_ff, nxt_pins;

  // sequence: address setup, strobe pulse, strobe release with hold
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_pins = pins_ff;
    unique case (state_ff)
      C_IDLE: begin
        nxt_pins.ce_n = 1'b1;
        nxt_pins.data_oe = 1'b0;
        if (start_i) begin
          nxt_req = req_i;
          nxt_pins.ce_n = 1'b0;
          nxt_pins.addr = req_i.addr;
          nxt_pins.data = req_i.data;
          nxt_pins.data_oe = req_i.write;
          nxt_state = C_SETUP;
        end
      end
      C_SETUP: begin
        nxt_pins.we_n = ~req_ff.write;
        nxt_pins.oe_n = req_ff.write;
        nxt_cnt = req_ff.write ? WE_PULSE_CYC : READ_ACCESS_CYC;
        nxt_state = C_PULSE;
      end
      C_PULSE: begin
        nxt_cnt = cnt_ff - 10'h001;
        if (cnt_ff == 10'h001) begin
          nxt_rdata = req_ff.write ? rdata_ff : data_i; // sample at end
          nxt_pins.we_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          nxt_state = C_HOLD;
        end
      end
      C_HOLD: begin
        nxt_pins.ce_n = 1'b1;
        nxt_done = 1'b1;
        nxt_state = C_IDLE;
      end
    endcase
  end

  // registers only
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_ff <= C_IDLE;
      req_ff <= '0;
      cnt_ff <= 10'h000;
      done_ff <= 1'b0;
      rdata_ff <= 8'h00;
      pins_ff <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, data_oe: 1'b0,
                   data: 8'h00, addr: '0};
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
      pins_ff <= nxt_pins;
    end
  end

  assign ready_o = (state_ff == C_IDLE) && !done_ff;
  assign done_o = done_ff;
  assign rdata_o = rdata_ff;
  assign pins_o = pins_ff;

endmodule

/* File: testbench/flash_host_ctrl_assertions.sv */
// flash_host_ctrl_assertions: port protocol checks for the controller.
// assumes a bind into flash_host_ctrl and its single clock domain.
`timescale 1ns/1ps
module flash_host_ctrl_assertions
  import flash_host_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic waitrequest_o,
  input wire logic [FLASH_AW-1:0] flash_addr_o,
  input wire logic flash_data_oe_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_oe_n_o,
  input wire logic reset_powerdown_pin_n_o,
  input wire logic protect_release_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [5:0] low_ff;
  logic [5:0] nxt_low;
  logic ctrl_wr;
  // strobe low-time counter
  always_comb nxt_low = (flash_we_n_o && flash_oe_n_o) ? 6'h00 :
    low_ff + 6'h01;
  always_ff @(posedge clock_i) low_ff <= reset_i ? 6'h00 : nxt_low;
  assign ctrl_wr = write_i && !waitrequest_o && address_i == REG_CTRL;
  chk_read_wait: assert property ($rose(read_i) |-> waitrequest_o ##1
    !waitrequest_o) else $error("read wait count wrong");
  chk_we_width: assert property ($rose(flash_we_n_o) |->
    low_ff == WE_PULSE_CYC[5:0]) else $error("write strobe width wrong");
  chk_oe_width: assert property ($rose(flash_oe_n_o) |->
    low_ff == READ_ACCESS_CYC[5:0]) else $error("read strobe width wrong");
  chk_strobe_excl: assert property (!(!flash_we_n_o && !flash_oe_n_o))
    else $error("both strobes low");
  chk_write_drives: assert property (!flash_we_n_o |-> flash_data_oe_o)
    else $error("write strobe without data drive");
  chk_ce_setup: assert property ($fell(flash_we_n_o) || $fell(flash_oe_n_o)
    |-> !$past(flash_ce_n_o)) else $error("strobe without chip select");
  chk_addr_hold:
    assert property (!flash_ce_n_o && !$past(flash_ce_n_o) |->
      $stable(flash_addr_o)) else $error("address moved in cycle");
  chk_ce_idle: assert property ($rose(flash_ce_n_o) |=> flash_ce_n_o)
    else $error("no idle cycle between cycles");
  chk_cmd_needs_rp:
    assert property (write_i && address_i == REG_CMD &&
      !reset_powerdown_pin_n_o |-> waitrequest_o)
      else $error("command taken while in reset");
  chk_rp_follow:
    assert property (ctrl_wr && !writedata_i[CTRL_RP_BIT] |-> ##[1:2]
      !reset_powerdown_pin_n_o) else $error("reset pin not driven");
  chk_protect_follow:
    assert property (ctrl_wr && writedata_i[CTRL_PROTECT_BIT] |-> ##[1:2]
      protect_release_o) else $error("protect pin not released");
endmodule

bind flash_host_ctrl flash_host_ctrl_assertions chk_inst (
  .clock_i(clock_i), .reset_i(reset_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
  .waitrequest_o(waitrequest_o), .flash_addr_o(flash_addr_o),
  .flash_data_oe_o(flash_data_oe_o), .flash_ce_n_o(flash_ce_n_o),
  .flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o),
  .reset_powerdown_pin_n_o(reset_powerdown_pin_n_o),
  .protect_release_o(protect_release_o)
);

/* File: testbench/flash_model.sv */
// flash_model: behavioural flash with status register and lock bits.
// assumes controller strobes and data are synchronous to clock_i.
`timescale 1ns/1ps
module flash_model
  import flash_host_pkg::*;
(
  input wire logic clock_i,
  input wire logic rp_n_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [FLASH_AW-1:0] addr_i,
  input wire logic [FLASH_DW-1:0] data_i,
  input wire logic wp_i,
  input wire logic vpp_ok_i,
  input wire logic slow_i,
  output logic [FLASH_DW-1:0] data_o,
  output logic sts_o
);
  logic [7:0] sr = 8'h80;
  logic [7:0] setup = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] out;
  logic [31:0] locks = 32'h0;
  logic [1:0] mode = 2'h0;
  logic [1:0] knd = 2'h0;
  logic stat = 1'b0;
  logic we_q = 1'b1;
  logic lk;
  int busy = 0;
  int pls = 0;
  // read data; inverted last byte when not driven
  assign lk = locks[addr_i[20:16]];
  assign out = stat ? sr : addr_i[7:0];
  assign data_o = (!ce_n_i && !oe_n_i) ? out : ~last;
  // pulled-up pin: low while busy in level mode, or pulsing
  assign sts_o = (mode == 2'h0) ? (busy == 0) : (pls == 0);
  function automatic logic [7:0] err(input logic blk, input logic [7:0] b);
    return !vpp_ok_i ? (b | 8'h08) : blk ? (b | 8'h02) : 8'h00;
  endfunction
  task automatic go(input logic [1:0] k, input logic [7:0] e, input int lop);
    busy <= slow_i ? 300 : 30;
    knd <= k;
    sr <= {1'b0, sr[6:0] | e[6:0]};
    stat <= 1'b1;
    if (e == 8'h00 && lop == 1) locks <= 32'h0;
    if (e == 8'h00 && lop == 2) locks[addr_i[20:16]] <= 1'b1;
  endtask
  task automatic cmd(input logic [7:0] d);
    setup <= 8'h00;
    case (setup)
      8'h60: begin
        if (d == 8'hD0) go(2'h1, err(!wp_i, 8'h20), 1);
        else if (d == 8'h01) go(2'h2, err(!wp_i, 8'h10), 2);
        else go(2'h0, 8'h30, 0);
      end
      8'h20: begin
        if (d == 8'hD0) go(2'h1, err(lk && !wp_i, 8'h20), 0);
        else go(2'h0, 8'h30, 0);
      end
      8'h30: go(2'h1, err(1'b0, 8'h20), 0);
      8'h40: go(2'h2, err(lk && !wp_i, 8'h10), 0);
      8'hB8: mode <= d[1:0];
      default: begin
        setup <= d;
        stat <= d != 8'hFF;
        if (d == 8'h50) sr[6:0] <= 7'h00;
      end
    endcase
  endtask
  // command latch at end of write strobe, engine timer, reset pin
  always @(posedge clock_i) begin
    we_q <= we_n_i;
    if (!ce_n_i && !oe_n_i) last <= out;
    if (!rp_n_i) begin
      if (busy > 0) locks <= ~locks;
      sr <= 8'h80;
      setup <= 8'h00;
      mode <= 2'h0;
      stat <= 1'b0;
      busy <= 0;
      pls <= 0;
    end else begin
      if (pls > 0) pls <= pls - 1;
      if (busy > 0) busy <= busy - 1;
      if (busy == 1) sr[7] <= 1'b1;
      if (busy == 1 && (mode == 2'h3 || mode == knd)) pls <= 4;
      if (we_n_i && !we_q && !ce_n_i) cmd(data_i);
    end
  end
endmodule

/* File: testbench/test_flash_host_ctrl.sv */
// test_flash_host_ctrl: self-checking bench for the flash controller.
// assumes flash_model as the device and an Avalon master in the bench.
`timescale 1ns/1ps
module test_flash_host_ctrl;
  import flash_host_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic vpp_ok = 1'b1;
  logic slow = 1'b0;
  logic [4:0] address_i = 5'h00;
  logic [31:0] writedata_i = 32'h0;
  logic [31:0] readdata_o, q;
  logic waitrequest_o, data_oe, ce_n, we_n, oe_n, rp_n, wp, sts;
  logic [FLASH_AW-1:0] faddr;
  logic [FLASH_DW-1:0] fdo, mrd, bus;
  logic [7:0] lfsr = 8'h60;
  logic [7:0] acc = 8'h00;
  logic [20:0] a = 21'h0;
  int error_cnt = 0;
  int n_tests = 0;
  // clock and shared data wire
  always #2 clock_i = ~clock_i;
  assign bus = data_oe ? fdo : mrd;
  flash_host_ctrl flash_host_ctrl_inst (
    .clock_i(clock_i), .reset_i(reset_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .flash_addr_o(faddr), .flash_data_o(fdo), .flash_data_oe_o(data_oe),
    .flash_data_i(bus), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n),
    .flash_oe_n_o(oe_n), .reset_powerdown_pin_n_o(rp_n),
    .protect_release_o(wp), .status_output_pin_i(sts)
  );
  flash_model flash_model_inst (
    .clock_i(clock_i), .rp_n_i(rp_n), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .addr_i(faddr), .data_i(bus), .wp_i(wp),
    .vpp_ok_i(vpp_ok), .slow_i(slow), .data_o(mrd), .sts_o(sts)
  );
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic timeout;
    cmp("wait", 32'h1, 32'h0);
    end_sim;
  endtask
  // one Avalon transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [4:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    address_i <= ad;
    writedata_i <= d;
    write_i <= w;
    read_i <= !w;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 5000);
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    if (n >= 5000) timeout;
  endtask
  task automatic poll;
    int n;
    n = 0;
    do begin
      av(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 600);
    if (n >= 600) timeout;
  endtask
  task automatic op(input op_t o, input logic [7:0] cfg, input logic [7:0] e);
    av(1'b1, REG_CMD, {16'h0, cfg, 4'h0, o});
    poll;
    if (e != 8'h00) cmp("status byte", {24'h0, e}, {24'h0, q[15:8]});
  endtask
  function automatic logic [7:0] expect_sr(input logic [7:0] e);
    acc = acc | e;
    return (8'h80 | acc) & SR_VALID_MASK;
  endfunction
  // new random flash address and engine speed
  task automatic new_addr;
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    a = {lfsr[4:0], 8'h00, lfsr};
    slow <= lfsr[7];
    av(1'b1, REG_ADDR, {11'h0, a});
    av(1'b1, REG_DATA, {24'h0, lfsr});
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    av(1'b0, REG_CTRL, 32'h0);
    cmp("ctrl reset", {28'h0, CTRL_RESET}, q);
    av(1'b0, REG_STATUS, 32'h0);
    cmp("pin mode", {30'h0, STS_LEVEL}, {30'h0, q[5:4]});
    av(1'b1, REG_CTRL, 32'h7);
    av(1'b1, 5'h18, 32'hF);
    av(1'b0, 5'h18, 32'h0);
    cmp("unmapped", 32'h0, q);
    av(1'b0, REG_CTRL, 32'h0);
    cmp("ctrl", 32'h7, q);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      op(OP_STS_CONFIG, 8'(c), 8'h00);
      av(1'b0, REG_STATUS, 32'h0);
      cmp("pin mode", 32'(c), {30'h0, q[5:4]});
      new_addr;
      op(OP_WORD_WRITE, 8'h00, 8'h80);
      op(OP_CLEAR_LOCKS, 8'h00, 8'h80);
    end
    $display("test pin modes done");
    new_addr;
    op(OP_SET_LOCK, 8'h00, 8'h80);
    cmp("lock", 32'h1, {31'h0, flash_model_inst.locks[a[20:16]]});
    av(1'b1, REG_CTRL, 32'h5);
    op(OP_BLOCK_ERASE, 8'h00, expect_sr(8'h22));
    op(OP_WORD_WRITE, 8'h00, expect_sr(8'h12));
    av(1'b0, REG_STATUS, 32'h0);
    cmp("sequence flag", 32'h1, {31'h0, q[STAT_SEQ_ERR_BIT]});
    op(OP_CHIP_ERASE, 8'h00, expect_sr(8'h00));
    op(OP_CLEAR_LOCKS, 8'h00, expect_sr(8'h22));
    vpp_ok <= 1'b0;
    av(1'b1, REG_CTRL, 32'h7);
    op(OP_CLEAR_LOCKS, 8'h00, expect_sr(8'h28));
    cmp("lock", 32'h1, {31'h0, flash_model_inst.locks[a[20:16]]});
    vpp_ok <= 1'b1;
    op(OP_CLEAR_STATUS, 8'h00, 8'h80);
    acc = 8'h00;
    op(OP_READ_STATUS, 8'h00, expect_sr(8'h00));
    op(OP_CLEAR_LOCKS, 8'h00, 8'h80);
    cmp("locks", 32'h0, flash_model_inst.locks);
    op(OP_READ_ARRAY, 8'h00, 8'h00);
    av(1'b0, REG_DATA, 32'h0);
    cmp("array byte", {24'h0, a[7:0]}, q);
    $display("test protection done");
    slow <= 1'b1;
    av(1'b1, REG_CMD, {28'h0, OP_CLEAR_LOCKS});
    repeat (120) @(posedge clock_i);
    av(1'b1, REG_CTRL, 32'h6);
    poll;
    cmp("locks unknown", 32'h1, {31'h0, q[STAT_LOCKS_UNKNOWN_BIT]});
    cmp("pin mode", 32'h0, {30'h0, q[5:4]});
    slow <= 1'b0;
    av(1'b1, REG_CTRL, 32'hF);
    op(OP_CLEAR_LOCKS, 8'h00, 8'h80);
    cmp("locks unknown", 32'h0, {31'h0, q[STAT_LOCKS_UNKNOWN_BIT]});
    cmp("array mode", 32'h0, {31'h0, flash_model_inst.stat});
    $display("test abort done");
    end_sim;
  end
endmodule
